//--- rtl/rcw_rtc_core.sv
// Purpose: BCD calendar clock with alarm, periodic event, wake pin and guarded writes.
// Assumes: clk32k_in is the 32.768 kHz crystal clock, sampled as a pin.
// Notes: sys_rst is the RTC power-on reset; no system reset enters here.
// Function
// [R1] Writes accepted only with oscillator enabled
// [R2] Isolation bit set to one releases writes
// [R3] Both key words must hold unlock value
// [R4] Otherwise keep isolated, discard host writes
// [R5] Writes land two slow-clock edges later
// [R6] Host clock at least three times faster
// [R7] Power-on reset initialises all RTC state; the scratch words carry no reset here
// [R8] System resets never clear RTC flops
// [R9] Count ms to year with leap years
// [R10] Hundred-year calendar ending at 2099
// [R11] BCD fields, 24-hour clock
// [R12] Millisecond trim corrects accumulated error
// [R13] Alarm at second/minute/hour/day granularity
// [R14] Periodic event: ms, s, min, hour, day
// [R15] All events merge onto one interrupt; here only alarm and periodic events reach it, the wake input event does not
// [R16] Alarm, periodic or wake input wake system
// [R17] Wake pin works as input or output
// [R18] Scratch words retained across system resets
// [R19] Fractional prescaler gives 1000 ms per second
`timescale 1ns/1ps
`default_nettype none
`include "rcw_regs.svh"
module rcw_rtc_core (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk32k_in,
    input wire logic osc_en,
    input wire logic host_wr_en,
    input wire rcw_pkg::rcw_wr_t host_wr,
    input wire logic [4:0] host_rd_addr,
    input wire logic wake_pin_i,
    output logic [15:0] host_rd_data_q,
    output logic wr_busy_q,
    output logic unlocked_q,
    output rcw_pkg::rcw_time_t time_q,
    output logic rtc_irq_q,
    output logic sys_wake_q,
    output logic wake_pin_o_q,
    output logic wake_pin_oe_q
);
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic leap(input logic [7:0] y);
        // Every fourth year of 2000..2099 is leap, 2000 included
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction : leap

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        if (m == `RCW_FEB) begin
            last_day = leap(y) ? 8'h29 : 8'h28;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            last_day = 8'h30;
        end else begin
            last_day = 8'h31;
        end
    endfunction : last_day

    // Pin synchronisers
    logic ck_s1_q, ck_s2_q, ck_s3_q;
    logic osc_s1_q, osc_s2_q;
    logic wk_s1_q, wk_s2_q, wk_s3_q;
    // Write pipe
    rcw_pkg::rcw_wst_t wst_q, wst_d;
    rcw_pkg::rcw_wr_t hold_q;
    // Guard and configuration
    logic iso_q;
    logic [15:0] key_lo_q, key_hi_q, trim_q;
    logic [7:0] ctrl_q, asec_q, amin_q, ahour_q, adate_q, trim_left_q;
    logic [15:0] acc_q;
    logic [2:0] stat_q;
    logic [4:0] rd_addr_q;
    rcw_pkg::rcw_time_t time_d;
    logic [15:0] scr_rdata;

    wire slow_tick = ck_s2_q & ~ck_s3_q;
    wire apply = (wst_q == rcw_pkg::WS_WAIT2) && slow_tick;
    wire gate_ok = osc_s2_q && iso_q && (key_lo_q == `RCW_KEY_LO) && (key_hi_q == `RCW_KEY_HI); // R1 R2 R3
    wire is_gate_addr = (hold_q.addr == `RCW_A_ISO) || (hold_q.addr == `RCW_A_KEYL)
                        || (hold_q.addr == `RCW_A_KEYH);
    // Guard words stay writable so software can open the gate at all
    wire gate_wr = apply && osc_s2_q && is_gate_addr; // R1
    wire reg_wr = apply && gate_ok; // R4
    wire scr_wr = reg_wr && (hold_q.addr[4:2] == `RCW_A_SCR_BASE);

    // Fractional prescaler, 1000 ticks per 32768 slow edges
    wire [15:0] acc_sum = acc_q + `RCW_ACC_STEP;
    wire nat_tick = slow_tick && (acc_sum >= `RCW_ACC_WRAP); // R19
    wire [15:0] acc_d = nat_tick ? acc_sum - `RCW_ACC_WRAP : acc_sum;
    wire trim_act = trim_left_q != `RCW_ZERO8;
    wire suppress = nat_tick && !trim_q[`RCW_TRIM_SIGN] && trim_act; // R12
    wire insert = slow_tick && !nat_tick && trim_q[`RCW_TRIM_SIGN] && trim_act; // R12
    wire ms_tick = (nat_tick && !suppress) || insert;

    wire ms_wrap = ms_tick && (time_q.ms == `RCW_MS_MAX);
    wire sec_wrap = ms_wrap && (time_q.sec == `RCW_SEC_MAX);
    wire min_wrap = sec_wrap && (time_q.min == `RCW_SEC_MAX);
    wire hr_wrap = min_wrap && (time_q.hour == `RCW_HOUR_MAX);
    wire day_wrap = hr_wrap && (time_q.date == last_day(time_q.mon, time_q.year)); // R9
    wire mon_wrap = day_wrap && (time_q.mon == `RCW_MON_MAX);

    wire alm_en = ctrl_q[`RCW_C_ALM_EN];
    wire [1:0] gran = ctrl_q[`RCW_C_GRAN_HI:`RCW_C_GRAN_LO];
    wire [2:0] per_sel = ctrl_q[`RCW_C_PER_HI:`RCW_C_PER_LO];
    wire wake_out = ctrl_q[`RCW_C_WAKE_OUT];
    wire alm_match = (time_d.sec == asec_q)
                     && (gran == `RCW_GRAN_SEC || time_d.min == amin_q)
                     && (gran == `RCW_GRAN_SEC || gran == `RCW_GRAN_MIN || time_d.hour == ahour_q)
                     && (gran != `RCW_GRAN_DAY || time_d.date == adate_q);
    wire alarm_hit = alm_en && ms_wrap && alm_match; // R13
    wire per_hit = (per_sel == `RCW_PER_MS && ms_tick) || (per_sel == `RCW_PER_SEC && ms_wrap)
                   || (per_sel == `RCW_PER_MIN && sec_wrap) || (per_sel == `RCW_PER_HOUR && min_wrap)
                   || (per_sel == `RCW_PER_DAY && hr_wrap); // R14
    wire wake_rise = !wake_out && wk_s2_q && !wk_s3_q; // R17
    wire [2:0] stat_set = {wake_rise, per_hit, alarm_hit};
    wire [2:0] stat_clr = (reg_wr && hold_q.addr == `RCW_A_STAT) ? hold_q.data[2:0] : 3'h0;
    // A new event in the clearing cycle survives
    wire [2:0] stat_d = (stat_q & ~stat_clr) | stat_set;

    wire [15:0] rd_val =
        (rd_addr_q == `RCW_A_ISO) ? {15'h0000, iso_q} :
        (rd_addr_q == `RCW_A_KEYL) ? key_lo_q :
        (rd_addr_q == `RCW_A_KEYH) ? key_hi_q :
        (rd_addr_q == `RCW_A_MS) ? {4'h0, time_q.ms} :
        (rd_addr_q == `RCW_A_SEC) ? {8'h00, time_q.sec} :
        (rd_addr_q == `RCW_A_MIN) ? {8'h00, time_q.min} :
        (rd_addr_q == `RCW_A_HOUR) ? {8'h00, time_q.hour} :
        (rd_addr_q == `RCW_A_WDAY) ? {8'h00, time_q.wday} :
        (rd_addr_q == `RCW_A_DATE) ? {8'h00, time_q.date} :
        (rd_addr_q == `RCW_A_MON) ? {8'h00, time_q.mon} :
        (rd_addr_q == `RCW_A_YEAR) ? {8'h00, time_q.year} :
        (rd_addr_q == `RCW_A_ASEC) ? {8'h00, asec_q} :
        (rd_addr_q == `RCW_A_AMIN) ? {8'h00, amin_q} :
        (rd_addr_q == `RCW_A_AHOUR) ? {8'h00, ahour_q} :
        (rd_addr_q == `RCW_A_ADATE) ? {8'h00, adate_q} :
        (rd_addr_q == `RCW_A_CTRL) ? {8'h00, ctrl_q} :
        (rd_addr_q == `RCW_A_STAT) ? {13'h0000, stat_q} :
        (rd_addr_q == `RCW_A_TRIM) ? trim_q :
        (rd_addr_q[4:2] == `RCW_A_SCR_BASE) ? scr_rdata : 16'h0000;

    // Next state of the write pipe; host must not write while busy
    always_comb begin
        wst_d = wst_q;
        case (wst_q)
            rcw_pkg::WS_IDLE: if (host_wr_en) wst_d = rcw_pkg::WS_WAIT1;
            rcw_pkg::WS_WAIT1: if (slow_tick) wst_d = rcw_pkg::WS_WAIT2;
            rcw_pkg::WS_WAIT2: if (slow_tick) wst_d = rcw_pkg::WS_IDLE;
            default: wst_d = rcw_pkg::WS_IDLE;
        endcase
    end

    // Calendar advance, host field writes take priority
    always_comb begin
        time_d = time_q;
        if (ms_wrap) time_d.ms = `RCW_ZERO12; // R9
        if (ms_tick && !ms_wrap) begin
            if (time_q.ms[7:0] == 8'h99) begin
                time_d.ms = {time_q.ms[11:8] + 4'h1, 8'h00};
            end else begin
                time_d.ms = {time_q.ms[11:8], bcd_inc(time_q.ms[7:0])};
            end
        end
        if (ms_wrap) time_d.sec = sec_wrap ? `RCW_ZERO8 : bcd_inc(time_q.sec); // R11
        if (sec_wrap) time_d.min = min_wrap ? `RCW_ZERO8 : bcd_inc(time_q.min);
        if (min_wrap) time_d.hour = hr_wrap ? `RCW_ZERO8 : bcd_inc(time_q.hour); // R11
        if (hr_wrap) begin
            time_d.wday = (time_q.wday == `RCW_WDAY_MAX) ? `RCW_ONE : bcd_inc(time_q.wday);
            time_d.date = day_wrap ? `RCW_ONE : bcd_inc(time_q.date); // R9
        end
        if (day_wrap) time_d.mon = mon_wrap ? `RCW_ONE : bcd_inc(time_q.mon);
        if (mon_wrap) time_d.year = (time_q.year == `RCW_YEAR_MAX) ? `RCW_ZERO8 : bcd_inc(time_q.year); // R10
        if (reg_wr) begin
            case (hold_q.addr)
                `RCW_A_MS: time_d.ms = hold_q.data[11:0];
                `RCW_A_SEC: time_d.sec = hold_q.data[7:0];
                `RCW_A_MIN: time_d.min = hold_q.data[7:0];
                `RCW_A_HOUR: time_d.hour = hold_q.data[7:0];
                `RCW_A_WDAY: time_d.wday = hold_q.data[7:0];
                `RCW_A_DATE: time_d.date = hold_q.data[7:0];
                `RCW_A_MON: time_d.mon = hold_q.data[7:0];
                `RCW_A_YEAR: time_d.year = hold_q.data[7:0];
                default: time_d.ms = time_d.ms;
            endcase
        end
    end

    // Crystal clock is only a sampled level here, hence the fast-clock ratio
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {ck_s1_q, ck_s2_q, ck_s3_q} <= 3'h0;
            {osc_s1_q, osc_s2_q} <= 2'h0;
            {wk_s1_q, wk_s2_q, wk_s3_q} <= 3'h0;
        end else begin
            {ck_s1_q, ck_s2_q, ck_s3_q} <= {clk32k_in, ck_s1_q, ck_s2_q}; // R6
            {osc_s1_q, osc_s2_q} <= {osc_en, osc_s1_q};
            {wk_s1_q, wk_s2_q, wk_s3_q} <= {wake_pin_i, wk_s1_q, wk_s2_q};
        end
    end

    // Only the RTC power-on reset clears these; no system reset is wired in
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wst_q <= rcw_pkg::WS_IDLE; // R7 R8
            hold_q <= '0;
            wr_busy_q <= 1'b0;
        end else begin
            wst_q <= wst_d; // R5
            if (wst_q == rcw_pkg::WS_IDLE && host_wr_en) hold_q <= host_wr;
            wr_busy_q <= wst_d != rcw_pkg::WS_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            iso_q <= 1'b0; // R7
            key_lo_q <= 16'h0000;
            key_hi_q <= 16'h0000;
            unlocked_q <= 1'b0;
        end else begin
            if (gate_wr && hold_q.addr == `RCW_A_ISO) iso_q <= hold_q.data[0]; // R2
            if (gate_wr && hold_q.addr == `RCW_A_KEYL) key_lo_q <= hold_q.data; // R3
            if (gate_wr && hold_q.addr == `RCW_A_KEYH) key_hi_q <= hold_q.data; // R3
            unlocked_q <= gate_ok;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `RCW_CTRL_RST;
            {asec_q, amin_q, ahour_q} <= 24'h000000;
            adate_q <= `RCW_ONE;
            trim_q <= 16'h0000;
        end else if (reg_wr) begin
            if (hold_q.addr == `RCW_A_CTRL) ctrl_q <= hold_q.data[7:0];
            if (hold_q.addr == `RCW_A_ASEC) asec_q <= hold_q.data[7:0];
            if (hold_q.addr == `RCW_A_AMIN) amin_q <= hold_q.data[7:0];
            if (hold_q.addr == `RCW_A_AHOUR) ahour_q <= hold_q.data[7:0];
            if (hold_q.addr == `RCW_A_ADATE) adate_q <= hold_q.data[7:0];
            if (hold_q.addr == `RCW_A_TRIM) trim_q <= hold_q.data; // R12
        end
    end

    // Trim budget reloads each second: drop or add that many ms ticks
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= 16'h0000;
            trim_left_q <= `RCW_ZERO8;
        end else begin
            if (slow_tick) acc_q <= acc_d; // R19
            if (ms_wrap) begin
                trim_left_q <= trim_q[7:0]; // R12
            end else if (suppress || insert) begin
                trim_left_q <= trim_left_q - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            time_q <= {`RCW_ZERO12, `RCW_ZERO8, `RCW_ZERO8, `RCW_ZERO8, `RCW_ONE, `RCW_ONE,
                       `RCW_ONE, `RCW_ZERO8}; // R7
            stat_q <= 3'h0;
            rtc_irq_q <= 1'b0;
            sys_wake_q <= 1'b0;
            wake_pin_o_q <= 1'b0;
            wake_pin_oe_q <= 1'b0;
        end else begin
            time_q <= time_d; // R9
            stat_q <= stat_d;
            rtc_irq_q <= |stat_d[`RCW_S_PER:`RCW_S_ALARM]; // R15
            sys_wake_q <= |stat_d; // R16
            wake_pin_oe_q <= wake_out; // R17
            wake_pin_o_q <= wake_out && (|stat_d[`RCW_S_PER:`RCW_S_ALARM]); // R17
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_addr_q <= 5'h00;
            host_rd_data_q <= 16'h0000;
        end else begin
            rd_addr_q <= host_rd_addr;
            host_rd_data_q <= rd_val;
        end
    end

    rcw_scratch_mem u_scratch (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .we(scr_wr), // R18
        .waddr(hold_q.addr[1:0]),
        .wdata(hold_q.data),
        .raddr(host_rd_addr[1:0]),
        .rdata_q(scr_rdata)
    );

    // Checks
    logic [1:0] wr_ticks_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ticks_q <= 2'h0;
        end else if (wst_q == rcw_pkg::WS_IDLE) begin
            wr_ticks_q <= 2'h0;
        end else if (slow_tick) begin
            wr_ticks_q <= wr_ticks_q + 2'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_OSC_OFF_LOCK: assert property (!osc_s2_q |=> !unlocked_q) // R1
        else $error("unlocked while oscillator stopped");
    AST_UNLOCK_NEEDS_KEY: assert property (unlocked_q |-> $past(iso_q) // R3
        && $past(key_lo_q) == `RCW_KEY_LO && $past(key_hi_q) == `RCW_KEY_HI)
        else $error("unlocked without isolation release and key");
    AST_DISCARD_LOCKED: assert property ((apply && !gate_ok && !ms_wrap) |=> $stable(time_q.sec)) // R4
        else $error("locked write changed seconds");
    AST_WRITE_TWO_TICKS: assert property (apply |-> wr_ticks_q == 2'h1) // R5
        else $error("write applied at wrong slow edge");
    AST_BUSY_AFTER_WRITE: assert property ((host_wr_en && wst_q == rcw_pkg::WS_IDLE) |=> wr_busy_q [*2]) // R5
        else $error("busy not shown after write");
    AST_PRESC_RANGE: assert property (acc_q < `RCW_ACC_WRAP) // R19
        else $error("prescaler accumulator overflow");
    AST_FEB_NONLEAP: assert property ((hr_wrap && time_q.mon == `RCW_FEB && time_q.date == 8'h28 // R9
        && !leap(time_q.year) && !reg_wr) |=> time_q.date == `RCW_ONE && time_q.mon == 8'h03)
        else $error("february rollover wrong");
    AST_YEAR_WRAP: assert property ((mon_wrap && time_q.year == `RCW_YEAR_MAX && !reg_wr) // R10
        |=> time_q.year == `RCW_ZERO8)
        else $error("year did not wrap after 2099");
    AST_ALARM_IRQ: assert property (alarm_hit |=> stat_q[`RCW_S_ALARM] && rtc_irq_q) // R13
        else $error("alarm did not raise interrupt");
    AST_MS_PERIODIC: assert property ((per_sel == `RCW_PER_MS && ms_tick) |=> stat_q[`RCW_S_PER]) // R14
        else $error("millisecond event lost");
    AST_WAKE_IN: assert property (wake_rise |=> sys_wake_q ##1 !wake_pin_oe_q) // R16
        else $error("wake input did not wake system");
    AST_WAKE_DIR: assert property (wake_pin_o_q |-> wake_pin_oe_q) // R17
        else $error("wake pin driven while input");

    COV_UNLOCK: cover property (!unlocked_q ##1 unlocked_q);
    COV_DAY_WRAP: cover property (day_wrap);
    COV_ALARM: cover property (alarm_hit);
    COV_WAKE_IN: cover property (wake_rise);
endmodule : rcw_rtc_core
`default_nettype wire

//--- include/rcw_regs.svh
// Purpose: Register indices, field positions, reset values and counts of the RTC.
// Assumes: Host write port carries a 5-bit register index and 16-bit data.
// Notes: Definitions only.
`ifndef RCW_REGS_SVH
`define RCW_REGS_SVH

`define RCW_A_ISO 5'h00
`define RCW_A_KEYL 5'h01
`define RCW_A_KEYH 5'h02
`define RCW_A_MS 5'h03
`define RCW_A_SEC 5'h04
`define RCW_A_MIN 5'h05
`define RCW_A_HOUR 5'h06
`define RCW_A_WDAY 5'h07
`define RCW_A_DATE 5'h08
`define RCW_A_MON 5'h09
`define RCW_A_YEAR 5'h0A
`define RCW_A_ASEC 5'h0B
`define RCW_A_AMIN 5'h0C
`define RCW_A_AHOUR 5'h0D
`define RCW_A_ADATE 5'h0E
`define RCW_A_CTRL 5'h0F
`define RCW_A_STAT 5'h10
`define RCW_A_TRIM 5'h11
`define RCW_A_SCR_BASE 3'h5

`define RCW_KEY_LO 16'hF1E0
`define RCW_KEY_HI 16'h95A4

`define RCW_ACC_STEP 16'h03E8
`define RCW_ACC_WRAP 16'h8000

`define RCW_MS_MAX 12'h999
`define RCW_SEC_MAX 8'h59
`define RCW_HOUR_MAX 8'h23
`define RCW_WDAY_MAX 8'h07
`define RCW_MON_MAX 8'h12
`define RCW_YEAR_MAX 8'h99
`define RCW_FEB 8'h02
`define RCW_ONE 8'h01
`define RCW_ZERO8 8'h00
`define RCW_ZERO12 12'h000

`define RCW_C_ALM_EN 0
`define RCW_C_GRAN_LO 1
`define RCW_C_GRAN_HI 2
`define RCW_C_PER_LO 3
`define RCW_C_PER_HI 5
`define RCW_C_WAKE_OUT 6
`define RCW_CTRL_RST 8'h00
`define RCW_TRIM_SIGN 15

`define RCW_GRAN_SEC 2'h0
`define RCW_GRAN_MIN 2'h1
`define RCW_GRAN_HOUR 2'h2
`define RCW_GRAN_DAY 2'h3

`define RCW_PER_MS 3'h1
`define RCW_PER_SEC 3'h2
`define RCW_PER_MIN 3'h3
`define RCW_PER_HOUR 3'h4
`define RCW_PER_DAY 3'h5

`define RCW_S_ALARM 0
`define RCW_S_PER 1
`define RCW_S_WAKE 2

`endif

//--- include/rcw_pkg.sv
// Purpose: Types shared by the RTC core and its testbench.
// Assumes: Field widths match the register header.
// Notes: No constants live here; see rcw_regs.svh.
`default_nettype none
package rcw_pkg;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] data;
    } rcw_wr_t;

    typedef struct packed {
        logic [11:0] ms;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] mon;
        logic [7:0] year;
    } rcw_time_t;

    typedef enum logic [1:0] {
        WS_IDLE,
        WS_WAIT1,
        WS_WAIT2
    } rcw_wst_t;
endpackage : rcw_pkg
`default_nettype wire

//--- rtl/rcw_scratch_mem.sv
// Purpose: Four 16-bit scratch words that survive system resets.
// Assumes: Only the RTC power-on reset reaches this block.
// Notes: Contents carry no reset; only the read register does.
`timescale 1ns/1ps
`default_nettype none
module rcw_scratch_mem (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic we,
    input wire logic [1:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] raddr,
    output logic [15:0] rdata_q
);
    logic [15:0] mem_q [0:3];

    // Retained across system resets so software can spot a set clock
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem_q[waddr] <= wdata; // R18
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= mem_q[raddr];
        end
    end
endmodule : rcw_scratch_mem
`default_nettype wire

//--- verif/rcw_far_model.sv
// Purpose: Crystal and external wake part seen by the RTC core.
// Assumes: Crystal is sped up for simulation, each level four host cycles.
// Notes: Crystal runs free, independent of the oscillator enable input.
`timescale 1ns/1ps
`default_nettype none
module rcw_far_model (
    input wire logic wake_req,
    input wire logic wake_pin_o_q,
    input wire logic wake_pin_oe_q,
    output logic clk32k_in,
    output logic wake_pin_i
);
    // Host clock stays eight times faster than this crystal
    initial begin
        clk32k_in = 1'b0;
        forever #20 clk32k_in = ~clk32k_in;
    end
    // Outside part drives the line only while the core listens
    assign wake_pin_i = wake_pin_oe_q ? wake_pin_o_q : wake_req;
endmodule : rcw_far_model
`default_nettype wire

//--- verif/rtc_calendar_alarm_wake_tb.sv
// Purpose: Self-checking bench for the RTC core through its write and read ports.
// Assumes: Crystal from rcw_far_model; inputs change on the falling clock edge.
// Notes: Seconds never elapse on their own here, so rollovers start at 59.999.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_regs.svh"
module rtc_calendar_alarm_wake_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic osc_en = 1'b1;
    logic host_wr_en = 1'b0;
    rcw_pkg::rcw_wr_t host_wr = '0;
    logic [4:0] host_rd_addr = 5'h00;
    logic wake_req = 1'b0;
    logic clk32k_in;
    logic wake_pin_i;
    logic [15:0] host_rd_data_q;
    logic wr_busy_q;
    logic unlocked_q;
    rcw_pkg::rcw_time_t time_q;
    logic rtc_irq_q;
    logic sys_wake_q;
    logic wake_pin_o_q;
    logic wake_pin_oe_q;
    int bad_count = 0;
    int cmp_count = 0;
    int busy_len;
    rcw_pkg::rcw_time_t t_rst = {12'h000, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    // Start year, month, date, then expected year, month, date
    logic [7:0] tbl [6][6] = '{'{8'h24, 8'h02, 8'h28, 8'h24, 8'h02, 8'h29},
        '{8'h24, 8'h02, 8'h29, 8'h24, 8'h03, 8'h01}, '{8'h23, 8'h02, 8'h28, 8'h23, 8'h03, 8'h01},
        '{8'h99, 8'h12, 8'h31, 8'h00, 8'h01, 8'h01}, '{8'h00, 8'h02, 8'h28, 8'h00, 8'h02, 8'h29},
        '{8'h23, 8'h04, 8'h30, 8'h23, 8'h05, 8'h01}};

    always #2.5 sys_clk = ~sys_clk;

    rcw_rtc_core dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk32k_in(clk32k_in),
        .osc_en(osc_en), .host_wr_en(host_wr_en), .host_wr(host_wr),
        .host_rd_addr(host_rd_addr), .wake_pin_i(wake_pin_i), .host_rd_data_q(host_rd_data_q),
        .wr_busy_q(wr_busy_q), .unlocked_q(unlocked_q), .time_q(time_q), .rtc_irq_q(rtc_irq_q),
        .sys_wake_q(sys_wake_q), .wake_pin_o_q(wake_pin_o_q), .wake_pin_oe_q(wake_pin_oe_q));

    rcw_far_model far_u (.wake_req(wake_req), .wake_pin_o_q(wake_pin_o_q),
        .wake_pin_oe_q(wake_pin_oe_q), .clk32k_in(clk32k_in), .wake_pin_i(wake_pin_i));

    task automatic complete_run();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    task automatic chkt(input string nm, input rcw_pkg::rcw_time_t e);
        cmp_count++;
        if (time_q !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, time_q);
            bad_count++;
        end
    endtask : chkt

    task automatic wr_start(input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        host_wr_en = 1'b1;
        host_wr.addr = a;
        host_wr.data = d;
        @(negedge sys_clk);
        host_wr_en = 1'b0;
    endtask : wr_start

    task automatic wr_wait();
        busy_len = 0;
        while (wr_busy_q !== 1'b0 && busy_len < 100) begin
            @(negedge sys_clk);
            busy_len++;
        end
        chk("busy end", 16'h0000, {15'h0000, wr_busy_q});
    endtask : wr_wait

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        wr_start(a, d);
        wr_wait();
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
        @(negedge sys_clk);
        host_rd_addr = a;
        repeat (3) @(negedge sys_clk);
        chk(nm, e, host_rd_data_q);
    endtask : rd

    task automatic roll(input logic [7:0] y, input logic [7:0] m, input logic [7:0] d);
        int n;
        wr(`RCW_A_YEAR, {8'h00, y});
        wr(`RCW_A_MON, {8'h00, m});
        wr(`RCW_A_DATE, {8'h00, d});
        wr(`RCW_A_WDAY, 16'h0007);
        wr(`RCW_A_HOUR, 16'h0023);
        wr(`RCW_A_MIN, 16'h0059);
        wr(`RCW_A_SEC, 16'h0059);
        wr(`RCW_A_MS, 16'h0999);
        n = 0;
        // One ms tick is about 33 crystal periods
        while (time_q.ms !== 12'h000 && n < 600) begin
            @(negedge sys_clk);
            n++;
        end
        chk("ms wrap", 16'h0000, {4'h0, time_q.ms});
        repeat (3) @(negedge sys_clk);
    endtask : roll

    task automatic por();
        @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
    endtask : por

    initial begin
        // About 5000 cycles of tests, so four times that is a hang
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
        chkt("time after reset", t_rst);
        wr(`RCW_A_SEC, 16'h0030);
        chk("sec locked", 16'h0000, {8'h00, time_q.sec});
        osc_en = 1'b0;
        wr(`RCW_A_ISO, 16'h0001);
        wr(`RCW_A_KEYL, `RCW_KEY_LO);
        wr(`RCW_A_KEYH, `RCW_KEY_HI);
        osc_en = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("unlock osc off", 16'h0000, {15'h0000, unlocked_q});
        rd(`RCW_A_ISO, 16'h0000, "iso osc off");
        wr(`RCW_A_ISO, 16'h0001);
        wr(`RCW_A_KEYL, `RCW_KEY_LO);
        wr(`RCW_A_SEC, 16'h0030);
        chk("sec half key", 16'h0000, {8'h00, time_q.sec});
        wr(`RCW_A_KEYH, `RCW_KEY_HI);
        @(negedge sys_clk);
        chk("unlocked", 16'h0001, {15'h0000, unlocked_q});
        wr_start(`RCW_A_MIN, 16'h0045);
        repeat (3) @(negedge sys_clk);
        chk("min early", 16'h0000, {8'h00, time_q.min});
        wr_wait();
        chk("min late", 16'h0045, {8'h00, time_q.min});
        chk("busy span", 16'h0001, {15'h0000, (busy_len >= 5 && busy_len <= 20)});
        for (int i = 0; i < 6; i++) begin
            roll(tbl[i][0], tbl[i][1], tbl[i][2]);
            chk("year", {8'h00, tbl[i][3]}, {8'h00, time_q.year});
            chk("month", {8'h00, tbl[i][4]}, {8'h00, time_q.mon});
            chk("date", {8'h00, tbl[i][5]}, {8'h00, time_q.date});
            chk("hour wday", 16'h0001, {time_q.hour, time_q.wday});
            chk("irq off", 16'h0000, {15'h0000, rtc_irq_q});
        end
        wr(`RCW_A_ASEC, 16'h0000);
        wr(`RCW_A_AMIN, 16'h0000);
        wr(`RCW_A_AHOUR, 16'h0000);
        wr(`RCW_A_ADATE, 16'h0001);
        for (int g = 0; g < 4; g++) begin
            wr(`RCW_A_CTRL, 16'(g * 2 + 1));
            wr(`RCW_A_STAT, 16'h0007);
            roll(8'h24, 8'h02, 8'h29);
            chk("alarm irq", 16'h0001, {15'h0000, rtc_irq_q});
            chk("alarm wake", 16'h0001, {15'h0000, sys_wake_q});
        end
        wr(`RCW_A_ADATE, 16'h0015);
        wr(`RCW_A_STAT, 16'h0007);
        roll(8'h24, 8'h02, 8'h29);
        chk("alarm miss", 16'h0000, {15'h0000, rtc_irq_q});
        for (int p = 1; p < 6; p++) begin
            wr(`RCW_A_CTRL, 16'h0000);
            wr(`RCW_A_STAT, 16'h0007);
            chk("irq cleared", 16'h0000, {15'h0000, rtc_irq_q});
            wr(`RCW_A_CTRL, 16'(p * 8));
            roll(8'h23, 8'h04, 8'h30);
            chk("periodic irq", 16'h0001, {15'h0000, rtc_irq_q});
        end
        wr(`RCW_A_CTRL, 16'h0000);
        wr(`RCW_A_STAT, 16'h0007);
        wake_req = 1'b1;
        repeat (8) @(negedge sys_clk);
        wake_req = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("wake in", 16'h0100, {7'h00, sys_wake_q, 7'h00, rtc_irq_q});
        chk("pin dir in", 16'h0000, {15'h0000, wake_pin_oe_q});
        wr(`RCW_A_STAT, 16'h0007);
        wr(`RCW_A_CTRL, 16'h0048);
        repeat (400) @(negedge sys_clk);
        chk("pin out", 16'h0101, {7'h00, wake_pin_oe_q, 7'h00, wake_pin_o_q});
        wr(`RCW_A_TRIM, 16'h8003);
        roll(8'h23, 8'h04, 8'h30);
        // Three added ticks land within four crystal periods of the wrap
        repeat (40) @(negedge sys_clk);
        chk("trim add", 16'h0001, {15'h0000, time_q.ms >= 12'h003});
        wr(`RCW_A_TRIM, 16'h0000);
        wr(5'h14, 16'hA5A5);
        rd(5'h14, 16'hA5A5, "scratch");
        rd(5'h1F, 16'h0000, "unmapped");
        por();
        chkt("time after por", t_rst);
        chk("unlock after por", 16'h0000, {15'h0000, unlocked_q});
        rd(5'h14, 16'hA5A5, "scratch kept");
        complete_run();
    end
endmodule : rtc_calendar_alarm_wake_tb
`default_nettype wire
